// [logic/uart_line_modem_control.v]
`timescale 1ns/100ps
`include "uart_lmc_regs.vh"
// Notes on behaviour
// - Ident register bits 4 and 5 always read zero.
// - Ident bits 6 and 7 read one while FIFO enable is set.
// - FIFO mode: timeout code 1100 after four idle char times, cleared by read.
// - Holding empty code 0010; cleared by ident read as source or data write.
// - Format bits 1:0 pick five to eight data bits.
// - Format bit 2 picks one, one and half, or two stop bits.
// - Receiver samples only the first stop bit.
// - Format bit 3 adds parity after data, before stop.
// - Format bit 4 low odd, high even parity over data plus parity.
// - Stick parity sends and expects inverse of bit 4.
// - Format bit 6 forces serial output low outside loopback.
// - Format bit 7 maps offsets 0 and 1 onto divisor latches.
// - Terminal-ready pin is inverse of control bit 0.
// - Request-to-send pin is inverse of control bit 1.
// - Control bit 2 is a pinless read-write flag, loopback source.
// - Control bit 3 gates the interrupt output enable.
// - Control bit 4 enters loopback and holds serial output high.
// - Loopback ignores serial input and feeds transmitter into receiver.
// - Loopback replaces modem inputs with control bits.
// - Loopback drives all modem control pins high.
// - Loopback keeps all interrupts, modem ones from control bits, enable-gated.
// - Control bits 5 to 7 read zero.
// - Ident bit 0 low when pending, high when idle.
// - Loopback status reads request, ready, spare and gate bits.
module uart_line_modem_control (
  input wire clk_sys,
  input wire rstn,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  output wire txd,
  input wire rxd,
  output wire dtr_n,
  output wire rts_n,
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire dcd_n,
  output wire irq,
  output wire irq_oe_n
);
  reg [7:0] line_format_control;
  reg [7:0] handshake_line_control;
  reg [7:0] ie;
  reg [7:0] scr;
  reg [15:0] div;
  reg fifo_en;
  reg [15:0] bcnt;
  reg tick;
  reg [7:0] thr;
  reg thr_full;
  reg thre_ip;
  reg [7:0] rbr;
  reg dr;
  reg oe, pe, fe, bi;
  reg [3:0] msr_delta;
  reg [3:0] msr_prev;
  reg [1:0] rx_s, cts_s, dsr_s, ri_s, dcd_s;
  reg [9:0] tmo_cnt;
  reg tmo_ip;
  reg [3:0] ident;
  wire loop_on;
  wire div_sel;
  wire [3:0] modem_in;
  wire tx_bit, tx_busy, rx_done, rx_perr, rx_ferr, rx_brk;
  wire [7:0] rx_byte;
  wire rx_src;
  wire tx_load;
  wire wr_data, rd_data, rd_ident, rd_lstat, rd_mstat;
  wire line_ip, rdata_ip, modem_ip;
  wire [7:0] lstat;
  wire [7:0] mstat;
  wire [7:0] ident_byte;
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign loop_on = handshake_line_control[`HLC_LOOP];
  assign div_sel = line_format_control[`LFC_DIV_SEL];
  assign wr_data = wr && addr == `OFS_DATA && !div_sel;
  assign rd_data = rd && addr == `OFS_DATA && !div_sel;
  assign rd_ident = rd && addr == `OFS_IDENT;
  assign rd_lstat = rd && addr == `OFS_LSTAT;
  assign rd_mstat = rd && addr == `OFS_MSTAT;
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      rx_s <= 2'b11;
      cts_s <= 2'b11;
      dsr_s <= 2'b11;
      ri_s <= 2'b11;
      dcd_s <= 2'b11;
    end else begin
      rx_s <= {rx_s[0], rxd};
      cts_s <= {cts_s[0], cts_n};
      dsr_s <= {dsr_s[0], dsr_n};
      ri_s <= {ri_s[0], ri_n};
      dcd_s <= {dcd_s[0], dcd_n};
    end
  end
  // Order: dcd, ri, dsr, cts (status bits 7..4)
  assign modem_in = loop_on ? {handshake_line_control[`HLC_IRQ_GATE],
                               handshake_line_control[`HLC_SPARE],
                               handshake_line_control[`HLC_DTR],
                               handshake_line_control[`HLC_RTS]}
                            : ~{dcd_s[1], ri_s[1], dsr_s[1], cts_s[1]};
  assign rx_src = loop_on ? tx_bit : rx_s[1];
  // ----------------------------------------
  // Pins
  // ----------------------------------------
  assign txd = loop_on ? 1'b1 : (line_format_control[`LFC_BREAK] ? 1'b0 : tx_bit);
  assign dtr_n = loop_on ? 1'b1 : ~handshake_line_control[`HLC_DTR];
  assign rts_n = loop_on ? 1'b1 : ~handshake_line_control[`HLC_RTS];
  // Pin released in loopback as the gate output is a control pin too
  assign irq_oe_n = ~(handshake_line_control[`HLC_IRQ_GATE] && !loop_on);
  assign irq = ident[0] == 1'b0;
  // ----------------------------------------
  // Baud tick, 16x
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      bcnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (wr && div_sel && (addr == `OFS_DATA || addr == `OFS_IE)) bcnt <= 16'h0000;
      else if (bcnt >= div - 16'h0001 || div == 16'h0000) begin
        bcnt <= 16'h0000;
        tick <= 1'b1;
      end else bcnt <= bcnt + 16'h0001;
    end
  end
  assign tx_load = thr_full && !tx_busy;
  uart_serial_engine u_engine (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tick(tick),
    .lfc(line_format_control),
    .tx_load(tx_load),
    .tx_byte(thr),
    .tx_busy(tx_busy),
    .tx_bit(tx_bit),
    .rx_in(rx_src),
    .rx_done(rx_done),
    .rx_byte(rx_byte),
    .rx_perr(rx_perr),
    .rx_ferr(rx_ferr),
    .rx_brk(rx_brk)
  );
  // ----------------------------------------
  // Registers and event flags
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      line_format_control <= `RST_LFC;
      handshake_line_control <= `RST_HLC;
      ie <= 8'h00;
      scr <= 8'h00;
      div <= `RST_DIV;
      fifo_en <= 1'b0;
      thr <= 8'h00;
      thr_full <= 1'b0;
      thre_ip <= 1'b0;
      rbr <= 8'h00;
      dr <= 1'b0;
      oe <= 1'b0;
      pe <= 1'b0;
      fe <= 1'b0;
      bi <= 1'b0;
      msr_delta <= 4'h0;
      msr_prev <= 4'h0;
      tmo_cnt <= 10'h000;
      tmo_ip <= 1'b0;
    end else begin
      msr_prev <= modem_in;
      if (wr) begin
        if (addr == `OFS_DATA) begin
          if (div_sel) div[7:0] <= wdata;
          else begin
            thr <= wdata;
            thr_full <= 1'b1;
          end
        end else if (addr == `OFS_IE) begin
          if (div_sel) div[15:8] <= wdata;
          else ie <= {4'h0, wdata[3:0]};
        end else if (addr == `OFS_IDENT) begin
          fifo_en <= wdata[0];
        end else if (addr == `OFS_LFC) begin
          line_format_control <= wdata;
        end else if (addr == `OFS_HLC) begin
          handshake_line_control <= {3'b000, wdata[4:0]};
        end else if (addr == `OFS_SCR) begin
          scr <= wdata;
        end
      end
      if (tx_load) thr_full <= 1'b0;
      // Holding-empty: set on transfer wins over any clear
      if (tx_load) thre_ip <= 1'b1;
      else if (wr_data || (rd_ident && ident == `ID_THRE)) thre_ip <= 1'b0;
      if (rd_data) dr <= 1'b0;
      if (rd_lstat) begin
        oe <= 1'b0;
        pe <= 1'b0;
        fe <= 1'b0;
        bi <= 1'b0;
      end
      if (rx_done) begin
        rbr <= rx_byte;
        dr <= 1'b1;
        if (dr && !rd_data) oe <= 1'b1;
        if (rx_perr) pe <= 1'b1;
        if (rx_ferr) fe <= 1'b1;
        if (rx_brk) bi <= 1'b1;
      end
      // Delta sources from control bits in loopback too
      msr_delta <= (rd_mstat ? 4'h0 : msr_delta)
                 | {modem_in[3] ^ msr_prev[3], ~modem_in[2] & msr_prev[2],
                    modem_in[1] ^ msr_prev[1], modem_in[0] ^ msr_prev[0]};
      // Idle counter in ticks; a read or a new byte restarts it
      if (!fifo_en || !dr || rd_data || rx_done) begin
        tmo_cnt <= 10'h000;
        if (rd_data || !fifo_en) tmo_ip <= 1'b0;
      end else if (tick) begin
        if (tmo_cnt == `TMO_CHARS * 11 * `OVERSAMPLE - 1) tmo_ip <= 1'b1;
        else tmo_cnt <= tmo_cnt + 10'h001;
      end
    end
  end
  // ----------------------------------------
  // Interrupt priority
  // ----------------------------------------
  assign line_ip = ie[2] && (oe || pe || fe || bi);
  assign rdata_ip = ie[0] && dr;
  assign modem_ip = ie[3] && (msr_delta != 4'h0);
  always @* begin
    if (line_ip) ident = `ID_LINE;
    else if (ie[0] && tmo_ip && fifo_en) ident = `ID_TMO;
    else if (rdata_ip) ident = `ID_RDATA;
    else if (ie[1] && thre_ip) ident = `ID_THRE;
    else if (modem_ip) ident = `ID_MODEM;
    else ident = `ID_NONE;
  end
  assign ident_byte = {fifo_en, fifo_en, 2'b00, ident};
  assign lstat = {1'b0, ~thr_full & ~tx_busy, ~thr_full, bi, fe, pe, oe, dr};
  assign mstat = {modem_in, msr_delta};
  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) rdata <= 8'h00;
    else if (rd) begin
      if (addr == `OFS_DATA) rdata <= div_sel ? div[7:0] : rbr;
      else if (addr == `OFS_IE) rdata <= div_sel ? div[15:8] : ie;
      else if (addr == `OFS_IDENT) rdata <= ident_byte;
      else if (addr == `OFS_LFC) rdata <= line_format_control;
      else if (addr == `OFS_HLC) rdata <= handshake_line_control;
      else if (addr == `OFS_LSTAT) rdata <= lstat;
      else if (addr == `OFS_MSTAT) rdata <= mstat;
      else rdata <= scr;
    end else rdata <= 8'h00;
  end
endmodule // uart_line_modem_control

// [pkg/uart_lmc_regs.vh]
`ifndef UART_LMC_REGS_VH
`define UART_LMC_REGS_VH
// Register offsets
`define OFS_DATA 3'h0
`define OFS_IE 3'h1
`define OFS_IDENT 3'h2
`define OFS_LFC 3'h3
`define OFS_HLC 3'h4
`define OFS_LSTAT 3'h5
`define OFS_MSTAT 3'h6
`define OFS_SCR 3'h7
// Line format fields
`define LFC_PAR_EN 3
`define LFC_EVEN 4
`define LFC_STICK 5
`define LFC_BREAK 6
`define LFC_DIV_SEL 7
// Handshake control fields
`define HLC_DTR 0
`define HLC_RTS 1
`define HLC_SPARE 2
`define HLC_IRQ_GATE 3
`define HLC_LOOP 4
// Ident codes
`define ID_NONE 4'h1
`define ID_LINE 4'h6
`define ID_RDATA 4'h4
`define ID_TMO 4'hC
`define ID_THRE 4'h2
`define ID_MODEM 4'h0
// Reset values
`define RST_LFC 8'h03
`define RST_HLC 8'h00
`define RST_DIV 16'h000D
// Timing
`define OVERSAMPLE 16
`define TMO_CHARS 4
`endif

// [logic/uart_serial_engine.v]
`timescale 1ns/100ps
`include "uart_lmc_regs.vh"
// Serial transmitter and receiver driven by a 16x tick
module uart_serial_engine (
  input wire clk_sys,
  input wire rstn,
  input wire tick,
  input wire [7:0] lfc,
  input wire tx_load,
  input wire [7:0] tx_byte,
  output reg tx_busy,
  output reg tx_bit,
  input wire rx_in,
  output reg rx_done,
  output reg [7:0] rx_byte,
  output reg rx_perr,
  output reg rx_ferr,
  output reg rx_brk
);
  localparam S_IDLE = 4'h1;
  localparam S_DATA = 4'h2;
  localparam S_PAR = 4'h4;
  localparam S_STOP = 4'h8;
  wire [3:0] nbits;
  wire par_tx;
  wire [3:0] stop_ticks;
  reg [3:0] ts;
  reg [3:0] tdiv;
  reg [3:0] tcnt;
  reg [5:0] tstop;
  reg [7:0] tsh;
  reg tpar;
  reg [3:0] rs;
  reg [3:0] rdiv;
  reg [3:0] rcnt;
  reg [7:0] rsh;
  reg rpar;
  reg rzero;
  assign nbits = {2'b00, lfc[1:0]} + 4'h5;
  // Even select and odd select both fold in the parity bit itself
  assign par_tx = lfc[`LFC_STICK] ? ~lfc[`LFC_EVEN] : (~lfc[`LFC_EVEN] ^ tpar);
  assign stop_ticks = 4'hF;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      ts <= S_IDLE;
      tx_busy <= 1'b0;
      tx_bit <= 1'b1;
      tdiv <= 4'h0;
      tcnt <= 4'h0;
      tstop <= 6'h00;
      tsh <= 8'h00;
      tpar <= 1'b0;
    end else begin
      case (ts)
        S_IDLE: begin
          tx_bit <= 1'b1;
          if (tx_load) begin
            tsh <= tx_byte;
            tpar <= 1'b0;
            tx_busy <= 1'b1;
            tx_bit <= 1'b0;
            tdiv <= 4'h0;
            tcnt <= 4'h0;
            ts <= S_DATA;
          end
        end
        S_DATA: if (tick) begin
          tdiv <= tdiv + 4'h1;
          if (tdiv == 4'hF) begin
            if (tcnt == nbits) begin
              if (lfc[`LFC_PAR_EN]) begin
                tx_bit <= par_tx;
                ts <= S_PAR;
              end else begin
                tx_bit <= 1'b1;
                tstop <= 6'h00;
                ts <= S_STOP;
              end
            end else begin
              tx_bit <= tsh[0];
              tpar <= tpar ^ tsh[0];
              tsh <= {1'b0, tsh[7:1]};
              tcnt <= tcnt + 4'h1;
            end
          end
        end
        S_PAR: if (tick) begin
          tdiv <= tdiv + 4'h1;
          if (tdiv == 4'hF) begin
            tx_bit <= 1'b1;
            tstop <= 6'h00;
            ts <= S_STOP;
          end
        end
        default: if (tick) begin
          tstop <= tstop + 6'h01;
          // 16, 24 or 32 ticks of stop
          if ((!lfc[2] && tstop == 6'd15) || (lfc[2] && lfc[1:0] == 2'b00 && tstop == 6'd23)
              || (lfc[2] && lfc[1:0] != 2'b00 && tstop == 6'd31)) begin
            tx_busy <= 1'b0;
            ts <= S_IDLE;
          end
        end
      endcase
    end
  end
  always @(posedge clk_sys) begin
    if (!rstn) begin
      rs <= S_IDLE;
      rdiv <= 4'h0;
      rcnt <= 4'h0;
      rsh <= 8'h00;
      rpar <= 1'b0;
      rzero <= 1'b1;
      rx_done <= 1'b0;
      rx_byte <= 8'h00;
      rx_perr <= 1'b0;
      rx_ferr <= 1'b0;
      rx_brk <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rs)
        S_IDLE: if (tick && !rx_in) begin
          rdiv <= 4'h0;
          rcnt <= 4'h0;
          rsh <= 8'h00;
          rpar <= 1'b0;
          rzero <= 1'b1;
          rs <= S_DATA;
        end
        S_DATA: if (tick) begin
          rdiv <= rdiv + 4'h1;
          // Start mid at 8, then every 16 ticks
          if (rcnt == 4'h0 && rdiv == 4'h7) begin
            if (rx_in) rs <= S_IDLE;
            else begin
              rdiv <= 4'h0;
              rcnt <= 4'h1;
            end
          end else if (rcnt != 4'h0 && rdiv == 4'hF) begin
            rsh <= {rx_in, rsh[7:1]};
            rpar <= rpar ^ rx_in;
            rzero <= rzero & ~rx_in;
            rcnt <= rcnt + 4'h1;
            if (rcnt == nbits) rs <= lfc[`LFC_PAR_EN] ? S_PAR : S_STOP;
          end
        end
        S_PAR: if (tick) begin
          rdiv <= rdiv + 4'h1;
          if (rdiv == 4'hF) begin
            rzero <= rzero & ~rx_in;
            rx_perr <= lfc[`LFC_STICK] ? (rx_in != ~lfc[`LFC_EVEN])
                     : ((rpar ^ rx_in) != ~lfc[`LFC_EVEN]);
            rs <= S_STOP;
          end
        end
        default: if (tick) begin
          rdiv <= rdiv + 4'h1;
          // Only the first stop bit is sampled
          if (rdiv == 4'hF) begin
            if (!lfc[`LFC_PAR_EN]) rx_perr <= 1'b0;
            rx_ferr <= ~rx_in;
            rx_brk <= rzero & ~rx_in;
            rx_byte <= rsh >> (4'h8 - nbits);
            rx_done <= 1'b1;
            rs <= S_IDLE;
          end
        end
      endcase
    end
  end
endmodule // uart_serial_engine

// [bench/uart_lmc_props.sv]
`timescale 1ns/100ps
module uart_lmc_props (
  input wire clk_sys,
  input wire rstn,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire txd,
  input wire dtr_n,
  input wire rts_n,
  input wire irq,
  input wire irq_oe_n
);
  // --------------------------------
  // Write shadows, same edge as design
  // --------------------------------
  reg [7:0] lfc;
  reg [7:0] hlc;
  reg [7:0] div_lo;
  reg fifo_on;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      lfc <= 8'h03;
      hlc <= 8'h00;
      div_lo <= 8'h0D;
      fifo_on <= 1'b0;
    end else if (wr) begin
      if (addr == 3'h3) lfc <= wdata;
      if (addr == 3'h4) hlc <= wdata;
      if (addr == 3'h0 && lfc[7]) div_lo <= wdata;
      if (addr == 3'h2) fifo_on <= wdata[0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_rd_ident;
    rd && addr == 3'h2;
  endsequence
  sequence s_rd_ctl;
    rd && addr == 3'h4;
  endsequence
  chk_ident_zero_bits: assert property (s_rd_ident |=> rdata[5:4] == 2'h0)
    else $error("ident bits 5:4 not zero");
  chk_ident_fifo_bits: assert property (s_rd_ident |=> rdata[7:6] == {2{$past(fifo_on)}})
    else $error("ident bits 7:6 wrong");
  chk_ident_pending: assert property (s_rd_ident ##0 !irq_oe_n |=> rdata[0] == !$past(irq))
    else $error("ident bit 0 disagrees with irq");
  chk_break_low: assert property (lfc[6] && !hlc[4] |-> !txd)
    else $error("txd not low in break");
  chk_loop_mark: assert property (hlc[4] |-> txd)
    else $error("txd not high in loopback");
  chk_dtr_pin: assert property (dtr_n == (~hlc[0] | hlc[4]))
    else $error("dtr_n wrong");
  chk_rts_pin: assert property (rts_n == (~hlc[1] | hlc[4]))
    else $error("rts_n wrong");
  chk_irq_gate: assert property (irq_oe_n == !(hlc[3] && !hlc[4]))
    else $error("irq_oe_n wrong");
  chk_ctl_readback: assert property (s_rd_ctl |=> rdata == {3'h0, $past(hlc[4:0])})
    else $error("control readback wrong");
  chk_div_map: assert property (rd && addr == 3'h0 && lfc[7] |=> rdata == $past(div_lo))
    else $error("divisor low not mapped");
  chk_loop_status: assert property (rd && addr == 3'h6 && hlc[4]
    |=> rdata[7:4] == {$past(hlc[3]), $past(hlc[2]), $past(hlc[0]), $past(hlc[1])})
    else $error("loopback status wrong");
endmodule // uart_lmc_props

// [bench/uart_far_end.sv]
`timescale 1ns/100ps
module uart_far_end (
  input wire clk_sys,
  input wire txd,
  output reg rxd,
  output reg cts_n,
  output reg dsr_n,
  output reg ri_n,
  output reg dcd_n
);
  // --------------------------------
  // Serial peer, idle at mark level
  // --------------------------------
  initial {rxd, cts_n, dsr_n, ri_n, dcd_n} = 5'h1F;
  task send(input [15:0] bits, input integer n, input integer bt);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        @(posedge clk_sys);
        rxd <= bits[j];
        repeat (bt - 1) @(posedge clk_sys);
      end
    end
  endtask
  // Observer only, so sample on the quiet edge
  task grab(output [15:0] bits, input integer n, input integer bt);
    integer j;
    begin
      bits = 16'hFFFF;
      j = 0;
      while (txd !== 1'b0 && j < 4000) begin
        @(negedge clk_sys);
        j = j + 1;
      end
      repeat (bt / 2) @(negedge clk_sys);
      for (j = 0; j < n; j = j + 1) begin
        bits[j] = txd;
        repeat (bt) @(negedge clk_sys);
      end
    end
  endtask
  task lines(input [4:0] v);
    begin
      @(posedge clk_sys);
      {rxd, cts_n, dsr_n, ri_n, dcd_n} <= v;
    end
  endtask
endmodule // uart_far_end

// [bench/uart_line_modem_control_bench.sv]
`timescale 1ns/100ps
`include "uart_lmc_regs.vh"
module uart_line_modem_control_bench;
  // Divisor 1: one tick per clock, 16 clocks per bit
  localparam integer BT = 16;
  localparam [47:0] FMTS = 48'h040D1A2B3B07;
  reg clk_sys = 1'b0;
  reg rstn = 1'b0;
  reg [2:0] addr = 3'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  wire [7:0] rdata;
  wire txd, rxd, dtr_n, rts_n, cts_n, dsr_n, ri_n, dcd_n, irq, irq_oe_n;
  integer n_fail = 0;
  integer n_checks = 0;
  integer cycles = 0;
  integer i;
  reg [7:0] d;
  reg [3:0] m;
  reg [7:0] lfc;
  reg [15:0] got;
  reg [7:0] rxq [$];
  uart_line_modem_control dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .txd(txd), .rxd(rxd), .dtr_n(dtr_n), .rts_n(rts_n),
    .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .irq(irq), .irq_oe_n(irq_oe_n));
  uart_far_end far (.clk_sys(clk_sys), .txd(txd), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n),
    .ri_n(ri_n), .dcd_n(dcd_n));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  // --------------------------------
  // Bus, compare and frame model
  // --------------------------------
  task tally_and_finish;
    begin
      if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task cmp8(input [7:0] g, input [7:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("Error %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task cmp_frame(input [15:0] g, input [15:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("Error %0t: frame %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr_reg(input [2:0] a, input [7:0] v);
    begin
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk_sys);
      wr <= 1'b0;
    end
  endtask
  task chk_rd(input [2:0] a, input [7:0] e, input [7:0] m);
    begin
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 cmp8(rdata & m, e & m);
    end
  endtask
  function integer frame_len(input [7:0] f);
    frame_len = 7 + f[1:0] + f[3] + (f[2] && f[1:0] != 2'h0);
  endfunction
  function [15:0] frame(input [7:0] f, input [7:0] v, input bad);
    integer j;
    reg x;
    begin
      frame = 16'hFFFE;
      x = 1'b0;
      for (j = 0; j < 5 + f[1:0]; j = j + 1) begin
        frame[j + 1] = v[j];
        x = x ^ v[j];
      end
      if (f[3]) frame[6 + f[1:0]] = (f[5] ? ~f[4] : (f[4] ? x : ~x)) ^ bad;
    end
  endfunction
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    d = $urandom(51376);
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    chk_rd(`OFS_IDENT, 8'h00, 8'hF0);
    for (i = 0; i < 8; i = i + 1) begin
      d = $urandom;
      wr_reg(`OFS_HLC, d);
      chk_rd(`OFS_HLC, d & 8'h1F, 8'hFF);
      cmp8({4'h0, txd, dtr_n, rts_n, irq_oe_n}, {4'h1, ~d[0] | d[4], ~d[1] | d[4], ~(d[3] & ~d[4])});
      m = $urandom;
      far.lines({1'b1, m});
      repeat (4) @(posedge clk_sys);
      if (d[4]) chk_rd(`OFS_MSTAT, {d[3], d[2], d[0], d[1], 4'h0}, 8'hF0);
      else chk_rd(`OFS_MSTAT, {~m[0], ~m[1], ~m[2], ~m[3], 4'h0}, 8'hF0);
    end
    wr_reg(`OFS_HLC, 8'h00);
    wr_reg(`OFS_LFC, 8'h43);
    #1 cmp8({7'h0, txd}, 8'h00);
    wr_reg(`OFS_HLC, 8'h10);
    #1 cmp8({7'h0, txd}, 8'h01);
    wr_reg(`OFS_LFC, 8'h83);
    wr_reg(`OFS_DATA, 8'h01);
    wr_reg(`OFS_IE, 8'h00);
    chk_rd(`OFS_DATA, 8'h01, 8'hFF);
    chk_rd(`OFS_IE, 8'h00, 8'hFF);
    wr_reg(`OFS_LFC, 8'h03);
    wr_reg(`OFS_IE, 8'h02);
    chk_rd(`OFS_IE, 8'h02, 8'hFF);
    wr_reg(`OFS_IDENT, 8'h01);
    wr_reg(`OFS_HLC, 8'h08);
    for (i = 0; i < 6; i = i + 1) begin
      lfc = FMTS[8 * i +: 8];
      d = $urandom;
      wr_reg(`OFS_LFC, lfc);
      fork
        far.grab(got, frame_len(lfc), BT);
        wr_reg(`OFS_DATA, d);
      join
      cmp_frame(got, frame(lfc, d, 1'b0) | (16'hFFFF << frame_len(lfc)));
      cmp8({7'h0, irq}, 8'h01);
      chk_rd(`OFS_IDENT, 8'hC2, 8'hFF);
      chk_rd(`OFS_IDENT, 8'hC1, 8'hFF);
    end
    // Two stops set, peer sends one: next start sits in the second stop slot
    wr_reg(`OFS_LFC, 8'h1F);
    for (i = 0; i < 2; i = i + 1) rxq.push_back($urandom);
    fork
      begin
        far.send(frame(8'h1B, rxq[0], 1'b0), 11, BT);
        far.send(frame(8'h1B, rxq[1], 1'b1), 11, BT);
      end
      begin
        repeat (11 * BT + 8) @(posedge clk_sys);
        chk_rd(`OFS_LSTAT, 8'h01, 8'h0F);
        chk_rd(`OFS_DATA, rxq.pop_front(), 8'hFF);
      end
    join
    repeat (24) @(posedge clk_sys);
    chk_rd(`OFS_LSTAT, 8'h05, 8'h0F);
    chk_rd(`OFS_DATA, rxq.pop_front(), 8'hFF);
    wr_reg(`OFS_LFC, 8'h03);
    wr_reg(`OFS_HLC, 8'h18);
    far.lines(5'h00);
    d = $urandom;
    wr_reg(`OFS_DATA, d);
    repeat (12 * BT) @(posedge clk_sys);
    chk_rd(`OFS_DATA, d, 8'hFF);
    chk_rd(`OFS_IDENT, 8'hC2, 8'hFF);
    far.lines(5'h1F);
    tally_and_finish;
  end
endmodule // uart_line_modem_control_bench
bind uart_line_modem_control uart_lmc_props chk (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .txd(txd), .dtr_n(dtr_n), .rts_n(rts_n),
  .irq(irq), .irq_oe_n(irq_oe_n));
